// [rtl/enid_regs.vh]
// constants for the ethernet node id and link indicator block
`ifndef ENID_REGS_VH
`define ENID_REGS_VH

// selector voltage step in millivolts and full scale
`define ENID_STEP_MV 16'h00C8
`define ENID_FULL_MV 16'h0BB8
// nibble layout of the node identifier
`define ENID_LO_LSB 0
`define ENID_HI_LSB 4
// clock and timing
`define ENID_CLK_HZ 10000000
`define ENID_SW_HZ 20000
`define ENID_PLS_MAX_HZ 5000
// cycles per limit switch toggle period at the 5 kHz maximum toggle rate
`define ENID_PLS_CYC (`ENID_CLK_HZ / `ENID_PLS_MAX_HZ)
// samples of the switching clock per toggle period
`define ENID_PLS_SAMPLES (`ENID_SW_HZ / `ENID_PLS_MAX_HZ)
// settle delay after reset before sampling selectors, in us
`define ENID_SETTLE_US 100
`define ENID_SETTLE_CYC (`ENID_SETTLE_US * (`ENID_CLK_HZ / 1000000))
// activity flicker off and on times, in ms
`define ENID_FLICK_OFF_MS 30
`define ENID_FLICK_ON_MS 30
`define ENID_FLICK_OFF_CYC (`ENID_FLICK_OFF_MS * (`ENID_CLK_HZ / 1000))
`define ENID_FLICK_ON_CYC (`ENID_FLICK_ON_MS * (`ENID_CLK_HZ / 1000))

`endif

// [rtl/enid_pls_limiter.v]
// toggle rate limiter for one programmable limit switch output
`timescale 1ns/1ps
`include "enid_regs.vh"

module enid_pls_limiter (
	// clock and reset
	input wire core_clk_in,
	input wire arst_n_in,
	// sample strobe, one pulse per switching period
	input wire sample_in,
	// requested and limited output levels
	input wire req_level_in,
	output reg pls_level_out
);

// samples to skip after an edge: half a toggle period less the edge's own
localparam integer HOLD_I = (`ENID_PLS_SAMPLES / 2) - 1;
localparam [3:0] HOLD_LAST = HOLD_I[3:0];

reg [3:0] hold_reg;

// -----------------------------------------------------------------
// output updates only on sample strobes, at most once per half toggle period
// -----------------------------------------------------------------
always @(posedge core_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		hold_reg <= 4'h0;
		pls_level_out <= 1'b0;
	end else if (sample_in) begin
		if (hold_reg != 4'h0) begin
			hold_reg <= hold_reg - 4'h1;
		end else if (req_level_in != pls_level_out) begin
			pls_level_out <= req_level_in;
			// half a toggle period in samples before the next edge
			hold_reg <= HOLD_LAST;
		end
	end
end

endmodule // enid_pls_limiter

// [rtl/enid_top.v]
// node id decode, link/activity indicator and limit switch rate limiting
`timescale 1ns/1ps
`include "enid_regs.vh"

module enid_top (
	// clock and reset
	input wire core_clk_in,
	input wire arst_n_in,
	// selector voltages from the converter, in millivolts
	input wire [15:0] node_id_low_nibble_select_in,
	input wire [15:0] node_id_high_nibble_select_in,
	input wire sel_valid_in,
	// stored fallback address
	input wire [7:0] nvm_addr_in,
	// ethernet status
	input wire link_valid_in,
	input wire traffic_in,
	// switching period sample strobe and requested limit switch level
	input wire sw_sample_in,
	input wire pls_req_in,
	// outputs
	output reg [7:0] ip_last_octet_out,
	output reg node_id_ready_out,
	output reg link_activity_indicator_out,
	output wire programmable_limit_switch_output_out
);

// -----------------------------------------------------------------
// state codes
// -----------------------------------------------------------------
// node id capture, one-hot
localparam ST_SETTLE = 3'b001;
localparam ST_SAMPLE = 3'b010;
localparam ST_DONE = 3'b100;

// indicator, one-hot
localparam LED_ON = 3'b001;
localparam LED_OFF = 3'b010;
localparam LED_HOLD = 3'b100;

// -----------------------------------------------------------------
// terminal counts, cut to the counter width on purpose
// -----------------------------------------------------------------
localparam integer SETTLE_LAST_I = `ENID_SETTLE_CYC - 1;
localparam integer FLICK_OFF_LAST_I = `ENID_FLICK_OFF_CYC - 1;
localparam integer FLICK_ON_LAST_I = `ENID_FLICK_ON_CYC - 1;

localparam [19:0] SETTLE_LAST = SETTLE_LAST_I[19:0];
localparam [19:0] FLICK_OFF_LAST = FLICK_OFF_LAST_I[19:0];
localparam [19:0] FLICK_ON_LAST = FLICK_ON_LAST_I[19:0];

localparam [19:0] CNT_ZERO = 20'h00000;
localparam [19:0] CNT_ONE = 20'h00001;

// -----------------------------------------------------------------
// counter helpers shared by the settle and flicker timers
// -----------------------------------------------------------------
function [19:0] cnt_inc;
	input [19:0] cnt;
	begin
		cnt_inc = cnt + CNT_ONE;
	end
endfunction

function cnt_done;
	input [19:0] cnt;
	input [19:0] last;
	begin
		// greater-or-equal also recovers a counter that overran
		cnt_done = (cnt >= last);
	end
endfunction

// -----------------------------------------------------------------
// millivolts to step count, rounded to nearest step and clipped to 15
// -----------------------------------------------------------------
function [3:0] mv_to_nibble;
	input [15:0] mv;
	reg [15:0] steps;
	begin
		steps = (mv + (`ENID_STEP_MV >> 1)) / `ENID_STEP_MV;
		if (mv >= `ENID_FULL_MV) begin
			mv_to_nibble = 4'hF;
		end else if (steps > 16'h000F) begin
			mv_to_nibble = 4'hF;
		end else begin
			mv_to_nibble = steps[3:0];
		end
	end
endfunction

// -----------------------------------------------------------------
// node id capture
// -----------------------------------------------------------------
reg [2:0] st_reg;
reg [2:0] st_next;
reg [19:0] settle_reg;
reg [19:0] settle_next;
reg [7:0] id_next;
reg [7:0] octet_next;
reg ready_next;

// decoded selectors, both nibbles
always @* begin
	id_next = 8'h00;
	id_next[`ENID_LO_LSB +: 4] = mv_to_nibble(node_id_low_nibble_select_in);
	id_next[`ENID_HI_LSB +: 4] = mv_to_nibble(node_id_high_nibble_select_in);
end

// settle, then take the selectors once
always @* begin
	st_next = st_reg;
	settle_next = settle_reg;
	octet_next = ip_last_octet_out;
	ready_next = node_id_ready_out;
	case (st_reg)
		ST_SETTLE: begin
			if (cnt_done(settle_reg, SETTLE_LAST)) begin
				st_next = ST_SAMPLE;
			end else begin
				settle_next = cnt_inc(settle_reg);
			end
		end
		ST_SAMPLE: begin
			if (sel_valid_in) begin
				if (id_next == 8'h00) begin
					// a zero selector id is replaced by the stored nvm_addr_in
					octet_next = nvm_addr_in;
				end else begin
					octet_next = id_next;
				end
				ready_next = 1'b1;
				st_next = ST_DONE;
			end
		end
		ST_DONE: begin
			// later selector changes are ignored until reset
			st_next = ST_DONE;
		end
		default: begin
			st_next = ST_SETTLE;
		end
	endcase
end

always @(posedge core_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		st_reg <= ST_SETTLE;
		settle_reg <= CNT_ZERO;
		ip_last_octet_out <= 8'h00;
		node_id_ready_out <= 1'b0;
	end else begin
		st_reg <= st_next;
		settle_reg <= settle_next;
		ip_last_octet_out <= octet_next;
		node_id_ready_out <= ready_next;
	end
end

// -----------------------------------------------------------------
// link/activity indicator
// -----------------------------------------------------------------
reg [2:0] led_reg;
reg [2:0] led_next;
reg [19:0] led_cnt_reg;
reg [19:0] led_cnt_next;
reg led_lit_next;

// off pulse per traffic event, then a minimum lit time
always @* begin
	led_next = led_reg;
	led_cnt_next = led_cnt_reg;
	led_lit_next = link_activity_indicator_out;
	if (!link_valid_in) begin
		led_next = LED_ON;
		led_cnt_next = CNT_ZERO;
		led_lit_next = 1'b0;
	end else begin
		case (led_reg)
			LED_ON: begin
				led_lit_next = 1'b1;
				if (traffic_in) begin
					led_next = LED_OFF;
					led_cnt_next = CNT_ZERO;
					led_lit_next = 1'b0;
				end
			end
			LED_OFF: begin
				led_lit_next = 1'b0;
				if (cnt_done(led_cnt_reg, FLICK_OFF_LAST)) begin
					led_next = LED_HOLD;
					led_cnt_next = CNT_ZERO;
					led_lit_next = 1'b1;
				end else begin
					led_cnt_next = cnt_inc(led_cnt_reg);
				end
			end
			LED_HOLD: begin
				// traffic is ignored so the flicker stays visible
				led_lit_next = 1'b1;
				if (cnt_done(led_cnt_reg, FLICK_ON_LAST)) begin
					led_next = LED_ON;
					led_cnt_next = CNT_ZERO;
				end else begin
					led_cnt_next = cnt_inc(led_cnt_reg);
				end
			end
			default: begin
				led_next = LED_ON;
				led_cnt_next = CNT_ZERO;
			end
		endcase
	end
end

always @(posedge core_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		led_reg <= LED_ON;
		led_cnt_reg <= CNT_ZERO;
		link_activity_indicator_out <= 1'b0;
	end else begin
		led_reg <= led_next;
		led_cnt_reg <= led_cnt_next;
		link_activity_indicator_out <= led_lit_next;
	end
end

// -----------------------------------------------------------------
// limit switch output, updated at the switching sample rate
// -----------------------------------------------------------------
enid_pls_limiter u_pls (
	.core_clk_in(core_clk_in),
	.arst_n_in(arst_n_in),
	.sample_in(sw_sample_in),
	.req_level_in(pls_req_in),
	.pls_level_out(programmable_limit_switch_output_out)
);

endmodule // enid_top

// [tb/enid_net_model.sv]
// model of the selector voltages and the ethernet link
`timescale 1ns/1ps
module enid_net_model (
	// from the bench
	input wire [3:0] lo_in,
	input wire [3:0] hi_in,
	input wire lk_in,
	input wire tr_in,
	// seen by the block
	output wire [15:0] lo_out,
	output wire [15:0] hi_out,
	output wire lk_out,
	output wire tr_out
);
	assign lo_out = {12'h000, lo_in} * 16'h00C8;
	assign hi_out = {12'h000, hi_in} * 16'h00C8;
	assign lk_out = lk_in;
	// traffic only exists on a live link
	assign tr_out = tr_in & lk_in;
endmodule // enid_net_model

// [tb/enid_chk_props.sv]
// assertions for the node id and indicator block
`timescale 1ns/1ps
module enid_chk (
	// watched ports
	input wire core_clk_in,
	input wire arst_n_in,
	input wire [15:0] node_id_low_nibble_select_in,
	input wire [15:0] node_id_high_nibble_select_in,
	input wire sel_valid_in,
	input wire [7:0] nvm_addr_in,
	input wire link_valid_in,
	input wire traffic_in,
	input wire sw_sample_in,
	input wire [7:0] ip_last_octet_out,
	input wire node_id_ready_out,
	input wire link_activity_indicator_out,
	input wire programmable_limit_switch_output_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	wire [7:0] id_w = {4'(node_id_high_nibble_select_in / 16'h00C8),
		4'(node_id_low_nibble_select_in / 16'h00C8)};
	wire [7:0] exp_w = (id_w == 8'h00) ? nvm_addr_in : id_w;
	wire led = link_activity_indicator_out;
	wire pls = programmable_limit_switch_output_out;
	// samples seen since the last output edge
	reg [1:0] smp_reg;
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			smp_reg <= 2'h2;
		else if ($changed(pls))
			smp_reg <= 2'h0;
		else if (sw_sample_in && smp_reg != 2'h3)
			smp_reg <= smp_reg + 2'h1;
	end
	a_id_value: assert property (
		$rose(node_id_ready_out) |-> ip_last_octet_out == $past(exp_w)) else $error("bad id");
	a_ready_cause: assert property (
		$rose(node_id_ready_out) |-> $past(sel_valid_in)) else $error("early id");
	a_id_held: assert property (
		node_id_ready_out |=> node_id_ready_out && $stable(ip_last_octet_out)) else $error("id moved");
	a_link_off: assert property (
		!link_valid_in |=> !led) else $error("led lit without link");
	a_idle_lit: assert property (
		link_valid_in && led && !traffic_in && !$past(traffic_in) && !$past(traffic_in, 2)
		|=> led || !link_valid_in)
		else $error("idle led dropped");
	a_flick_off: assert property (
		link_valid_in && $past(link_valid_in) && $fell(led) |=> !led) else $error("short flicker");
	a_pls_sample: assert property (
		$changed(pls) |-> $past(sw_sample_in)) else $error("output moved off sample");
	a_pls_rate: assert property (
		$changed(pls) |-> smp_reg[1]) else $error("output too fast");
	c_id: cover property ($rose(node_id_ready_out));
	c_flick: cover property ($fell(led) && link_valid_in);
	c_pls: cover property ($changed(pls));
endmodule // enid_chk
bind enid_top enid_chk u_chk (.*);

// [tb/tb.sv]
// self-checking bench for the node id and indicator block
`timescale 1ns/1ps
module tb;
	reg core_clk_in = 1'b0, arst_n_in = 1'b0, link_r = 1'b0, burst_r = 1'b0;
	reg sv_r = 1'b0, smp_r = 1'b0, req_r = 1'b0;
	reg [3:0] hi_r = 4'h0, lo_r = 4'h0;
	reg [7:0] nvm_r = 8'h00;
	reg [31:0] rng = 32'h00012573;
	integer mismatches = 0, tests_run = 0, k;
	wire [15:0] lo_mv, hi_mv;
	wire link_w, traf_w, rdy, led, pls;
	wire [7:0] oct;
	enid_net_model net (.lo_in(lo_r), .hi_in(hi_r), .lk_in(link_r), .tr_in(burst_r),
		.lo_out(lo_mv), .hi_out(hi_mv), .lk_out(link_w), .tr_out(traf_w));
	enid_top uut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.node_id_low_nibble_select_in(lo_mv), .node_id_high_nibble_select_in(hi_mv),
		.sel_valid_in(sv_r), .nvm_addr_in(nvm_r), .link_valid_in(link_w),
		.traffic_in(traf_w), .sw_sample_in(smp_r), .pls_req_in(req_r),
		.ip_last_octet_out(oct), .node_id_ready_out(rdy),
		.link_activity_indicator_out(led), .programmable_limit_switch_output_out(pls));
	// ----
	// helpers
	// ----
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function [7:0] exp_id(input [7:0] id, input [7:0] n);
		exp_id = (id == 8'h00) ? n : id;
	endfunction
	task automatic tick(input integer n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task check(input [7:0] got, input [7:0] want);
		tests_run = tests_run + 1;
		if (got !== want) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// stimulus
	// ----
	initial forever #50 core_clk_in = ~core_clk_in;
	// switching sample every 10 cycles keeps the run short
	initial forever begin
		tick(9);
		smp_r = 1'b1;
		tick(1);
		smp_r = 1'b0;
	end
	initial begin
		#4000000;
		mismatches = mismatches + 1;
		complete_run;
	end
	initial begin
		for (k = 0; k < 7; k = k + 1) begin
			rng = xs(rng);
			{hi_r, lo_r} = (k < 4) ? 8'(32'hFF01FD00 >> (8 * k)) : rng[15:8];
			nvm_r = rng[7:0];
			arst_n_in = 1'b0;
			sv_r = 1'b0;
			tick(20);
			arst_n_in = 1'b1;
			tick(1200);
			check({7'h00, rdy}, 8'h00);
			sv_r = 1'b1;
			tick(3);
			check(oct, exp_id({hi_r, lo_r}, nvm_r));
			{hi_r, lo_r} = ~{hi_r, lo_r};
			tick(3);
			check(oct, exp_id(~{hi_r, lo_r}, nvm_r));
		end
		link_r = 1'b1;
		tick(3);
		check({7'h00, led}, 8'h01);
		burst_r = 1'b1;
		tick(1);
		burst_r = 1'b0;
		tick(4);
		check({7'h00, led}, 8'h00);
		link_r = 1'b0;
		tick(2);
		check({7'h00, led}, 8'h00);
		for (k = 0; k < 302; k = k + 1) begin
			rng = xs(rng);
			req_r = (k < 300) ? rng[0] : k[0];
			tick((k < 300) ? 1 : 50);
			if (k >= 300) check({7'h00, pls}, {7'h00, k[0]});
		end
		complete_run;
	end
endmodule // tb
